// ### shared/acf_pkg.sv
// Constants, offsets and field layout of the converter control front end.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package acf_pkg;
  localparam int          ACF_ADDR_W     = 5;
  localparam int          ACF_CH_N       = 7;
  // Register byte addresses
  localparam logic [4:0]  ACF_OFF_PIN_EN = 5'h00;
  localparam logic [4:0]  ACF_OFF_CTRL   = 5'h04;
  localparam logic [4:0]  ACF_OFF_TRIM   = 5'h08;
  localparam logic [4:0]  ACF_OFF_STAT   = 5'h0C;
  localparam logic [4:0]  ACF_OFF_RESULT = 5'h10;
  // Control field positions
  localparam int          ACF_CTRL_DIV   = 5;
  localparam int          ACF_CTRL_RUN   = 4;
  localparam int          ACF_CTRL_PWR   = 3;
  localparam int          ACF_CTRL_CH    = 0;
  // Trim field positions
  localparam int          ACF_TRIM_CAL   = 7;
  localparam int          ACF_TRIM_SIGN  = 6;
  localparam int          ACF_TRIM_MAG   = 3;
  // Status field positions
  localparam int          ACF_STAT_DONE  = 0;
  localparam int          ACF_STAT_WAKE  = 1;
  localparam int          ACF_STAT_RTYPE = 2;
  // Reset values
  localparam logic [6:0]  ACF_RST_PIN_EN = 7'h00;
  localparam logic [1:0]  ACF_RST_DIV    = 2'h0;
  localparam logic [2:0]  ACF_RST_CH     = 3'h0;
  localparam logic [2:0]  ACF_RST_MAG    = 3'h0;
  // Divider codes and ratios
  localparam logic [1:0]  ACF_DIV_16     = 2'h0;
  localparam logic [1:0]  ACF_DIV_4      = 2'h1;
  localparam logic [1:0]  ACF_DIV_64     = 2'h2;
  localparam logic [1:0]  ACF_DIV_8      = 2'h3;
  localparam logic [5:0]  ACF_LAST_16    = 6'hF;
  localparam logic [5:0]  ACF_LAST_4     = 6'h3;
  localparam logic [5:0]  ACF_LAST_64    = 6'h3F;
  localparam logic [5:0]  ACF_LAST_8     = 6'h7;
  // Channel codes of shared pins
  localparam logic [2:0]  ACF_CH_IR      = 3'h4;
  localparam logic [2:0]  ACF_CH_OSC_OUT = 3'h5;
  localparam logic [2:0]  ACF_CH_OSC_IN  = 3'h6;
  localparam logic [2:0]  ACF_CH_NONE    = 3'h7;
  // Bus responses
  localparam logic [1:0]  ACF_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  ACF_RESP_ERR   = 2'h2;

  function automatic logic [6:0] acf_ch_onehot(input logic [2:0] code);
    acf_ch_onehot = (code == ACF_CH_NONE) ? 7'h00 : 7'(7'h01 << code);
  endfunction : acf_ch_onehot
endpackage : acf_pkg

// ### shared/acf_reg_if.sv
// Register access carrier between the bus slave and the register file.
// Assumes both ends share aclk; all signals are same-cycle.
`timescale 1ns/100ps
interface acf_reg_if;
  import acf_pkg::*;
  logic                  wr_en;
  logic [ACF_ADDR_W-1:0] wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic                  wr_hit;
  logic [ACF_ADDR_W-1:0] rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_hit;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                input  wr_hit, rd_data, rd_hit);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : acf_reg_if

// ### logic/acf_clk_div.sv
// Conversion clock divider: one-cycle enable pulse every 4, 8, 16 or 64 clocks.
// Assumes the ratio code is steady while run is high.
`timescale 1ns/100ps
module acf_clk_div (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] ratio,
  // Output
  output logic            tick
);
  import acf_pkg::*;

  typedef struct packed {
    logic [5:0] count;
    logic       tick;
  } acf_div_s;

  acf_div_s state;
  acf_div_s next_state;
  logic [5:0] last;

  always_comb begin
    unique case (ratio)
      ACF_DIV_16: last = ACF_LAST_16;
      ACF_DIV_4:  last = ACF_LAST_4;
      ACF_DIV_64: last = ACF_LAST_64;
      ACF_DIV_8:  last = ACF_LAST_8;
    endcase
    next_state = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.count = 6'h00;
    end else if (state.count >= last) begin
      next_state.count = 6'h00;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = 6'(state.count + 6'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule : acf_clk_div

// ### logic/acf_axil_slave.sv
// AXI4-Lite slave: one write and one read at a time, SLVERR when unmapped.
// Assumes the register side decodes combinationally through the carrier.
`timescale 1ns/100ps
module acf_axil_slave (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Write address and data
  input  wire logic [acf_pkg::ACF_ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // Write response
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // Read
  input  wire logic [acf_pkg::ACF_ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Register side
  acf_reg_if.bus                             reg_port
);
  import acf_pkg::*;

  typedef struct packed {
    logic                  aw_held;
    logic                  w_held;
    logic [ACF_ADDR_W-1:0] addr;
    logic [31:0]           data;
    logic [3:0]            strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } acf_bus_s;

  acf_bus_s state;
  acf_bus_s next_state;

  assign awready = !state.aw_held && !state.bvalid;
  assign wready  = !state.w_held && !state.bvalid;
  assign arready = !state.rvalid;

  always_comb begin
    next_state = state;
    if (awvalid && awready) begin
      next_state.aw_held = 1'b1;
      next_state.addr    = awaddr;
    end
    if (wvalid && wready) begin
      next_state.w_held = 1'b1;
      next_state.data   = wdata;
      next_state.strb   = wstrb;
    end
    // Both halves present: commit and answer next edge
    if (state.aw_held && state.w_held) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = reg_port.wr_hit ? ACF_RESP_OKAY : ACF_RESP_ERR;
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = reg_port.rd_data;
      next_state.rresp  = reg_port.rd_hit ? ACF_RESP_OKAY : ACF_RESP_ERR;
    end else if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_port.wr_en   = state.aw_held && state.w_held;
  assign reg_port.wr_addr = state.addr;
  assign reg_port.wr_data = state.data;
  assign reg_port.wr_strb = state.strb;
  assign reg_port.rd_addr = araddr;
  assign bvalid           = state.bvalid;
  assign bresp            = state.bresp;
  assign rvalid           = state.rvalid;
  assign rresp            = state.rresp;
  assign rdata            = state.rdata;
endmodule : acf_axil_slave

// ### logic/adc_control_front_end.sv
// Converter control front end: registers, start/complete sequencing,
// pin sharing priority, offset trim and wake-up reporting.
// Assumes the converter core and pin logic run on aclk; no synchronisers.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module adc_control_front_end #(
  parameter int RESULT_W = 12
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [acf_pkg::ACF_ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // AXI4-Lite write response
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // AXI4-Lite read
  input  wire logic [acf_pkg::ACF_ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Converter core
  output logic                               conv_start,
  output logic                               conv_clk_en,
  input  wire logic                          conv_done,
  input  wire logic [RESULT_W-1:0]           conv_result,
  output logic                               ref_power_on,
  output logic [acf_pkg::ACF_CH_N-1:0]       channel_onehot,
  // Offset trim
  output logic                               offset_cal_enable,
  output logic                               offset_positive,
  output logic [3:0]                         offset_lsb,
  // Pin sharing
  input  wire logic                          osc_in_use,
  input  wire logic                          ir_output_enable,
  output logic [acf_pkg::ACF_CH_N-1:0]       analog_route,
  output logic [acf_pkg::ACF_CH_N-1:0]       digital_io_enable,
  output logic                               ir_drive,
  // Sleep and wake-up
  input  wire logic                          sleep_mode,
  input  wire logic                          pin_change_wake,
  input  wire logic                          comparator_wake,
  input  wire logic                          other_wake,
  output logic                               wake_request,
  output logic                               reset_type
);
  import acf_pkg::*;

  initial begin
    if (RESULT_W < 1 || RESULT_W > 32) begin
      $error("RESULT_W must lie between 1 and 32");
    end
    // Pin masks below assume seven channels
    if (ACF_CH_N != 7) begin
      $error("ACF_CH_N must be 7");
    end
  end

  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    logic [6:0]          pin_en;
    logic [1:0]          div;
    logic                run;
    logic                pwr;
    logic [2:0]          chsel;
    logic                cal;
    logic                sign;
    logic [2:0]          mag;
    logic                done;
    logic                wake_en;
    logic                rtype;
    logic                wake;
    logic                start;
    logic [RESULT_W-1:0] result;
  } acf_state_s;

  acf_state_s state;
  acf_state_s next_state;
  logic       wr_low;
  logic       completed;
  logic       adc_wake;
  logic       osc_block;

  // Carrier between bus slave and registers
  acf_reg_if reg_port ();

  // ******************************************************************
  // Bus slave and divider
  // ******************************************************************
  acf_axil_slave u_bus (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .awaddr   (awaddr),
    .awvalid  (awvalid),
    .awready  (awready),
    .wdata    (wdata),
    .wstrb    (wstrb),
    .wvalid   (wvalid),
    .wready   (wready),
    .bresp    (bresp),
    .bvalid   (bvalid),
    .bready   (bready),
    .araddr   (araddr),
    .arvalid  (arvalid),
    .arready  (arready),
    .rdata    (rdata),
    .rresp    (rresp),
    .rvalid   (rvalid),
    .rready   (rready),
    .reg_port (reg_port.bus)
  );

  // Divider only runs while a powered conversion is under way
  acf_clk_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (state.run && state.pwr),
    .ratio   (state.div),
    .tick    (conv_clk_en)
  );

  // ******************************************************************
  // Register decode
  // ******************************************************************
  function automatic logic acf_mapped(input logic [ACF_ADDR_W-1:0] a);
    acf_mapped = (a == ACF_OFF_PIN_EN) || (a == ACF_OFF_CTRL) ||
                 (a == ACF_OFF_TRIM) || (a == ACF_OFF_STAT) ||
                 (a == ACF_OFF_RESULT);
  endfunction : acf_mapped

  assign reg_port.wr_hit = acf_mapped(reg_port.wr_addr);
  assign reg_port.rd_hit = acf_mapped(reg_port.rd_addr);
  // Registers live in byte lane 0 only
  assign wr_low = reg_port.wr_en && reg_port.wr_strb[0];

  always_comb begin
    reg_port.rd_data = 32'h0000_0000;
    unique case (reg_port.rd_addr)
      ACF_OFF_PIN_EN: begin
        // Bit seven is never stored
        reg_port.rd_data[6:0] = state.pin_en;
      end
      ACF_OFF_CTRL: begin
        reg_port.rd_data[ACF_CTRL_DIV+:2] = state.div;
        reg_port.rd_data[ACF_CTRL_RUN]    = state.run;
        reg_port.rd_data[ACF_CTRL_PWR]    = state.pwr;
        reg_port.rd_data[ACF_CTRL_CH+:3]  = state.chsel;
      end
      ACF_OFF_TRIM: begin
        reg_port.rd_data[ACF_TRIM_CAL]    = state.cal;
        reg_port.rd_data[ACF_TRIM_SIGN]   = state.sign;
        reg_port.rd_data[ACF_TRIM_MAG+:3] = state.mag;
      end
      ACF_OFF_STAT: begin
        reg_port.rd_data[ACF_STAT_DONE]  = state.done;
        reg_port.rd_data[ACF_STAT_WAKE]  = state.wake_en;
        reg_port.rd_data[ACF_STAT_RTYPE] = state.rtype;
      end
      ACF_OFF_RESULT: begin
        // Bits above the result read zero
        reg_port.rd_data[RESULT_W-1:0] = state.result;
      end
      default: reg_port.rd_data = 32'h0000_0000;
    endcase
  end

  // ******************************************************************
  // Sequencing
  // ******************************************************************
  // Completion only counts for a powered, running conversion
  assign completed = conv_done && state.run && state.pwr;
  // Converter wakes only with its enable bit set
  assign adc_wake  = completed && state.wake_en;

  always_comb begin
    next_state       = state;
    next_state.start = 1'b0;
    next_state.wake  = 1'b0;

    if (wr_low) begin
      unique case (reg_port.wr_addr)
        ACF_OFF_PIN_EN: begin
          // Bit seven is dropped, not stored
          next_state.pin_en = reg_port.wr_data[6:0];
        end
        ACF_OFF_CTRL: begin
          next_state.div = reg_port.wr_data[ACF_CTRL_DIV+:2];
          next_state.pwr = reg_port.wr_data[ACF_CTRL_PWR];
          // Select frozen while busy or unread; other bits still land
          if (!state.run && !state.done) begin
            next_state.chsel = reg_port.wr_data[ACF_CTRL_CH+:3];
          end
          // Zero write never clears run
          if (reg_port.wr_data[ACF_CTRL_RUN] && !state.run &&
              reg_port.wr_data[ACF_CTRL_PWR]) begin
            next_state.run   = 1'b1;
            next_state.start = 1'b1;
          end
        end
        ACF_OFF_TRIM: begin
          next_state.cal  = reg_port.wr_data[ACF_TRIM_CAL];
          next_state.sign = reg_port.wr_data[ACF_TRIM_SIGN];
          // Bits two to zero are not stored
          next_state.mag  = reg_port.wr_data[ACF_TRIM_MAG+:3];
        end
        ACF_OFF_STAT: begin
          next_state.wake_en = reg_port.wr_data[ACF_STAT_WAKE];
          if (reg_port.wr_data[ACF_STAT_DONE]) begin
            next_state.done = 1'b0;
          end
        end
        default: begin
          // Unmapped or read-only: nothing changes
          next_state.pin_en = state.pin_en;
        end
      endcase
    end

    // Hardware set placed last so it wins over a same-cycle clear
    if (completed) begin
      next_state.result = conv_result;
      next_state.run    = 1'b0;
      next_state.done   = 1'b1;
    end

    // Reset type only moves while asleep
    if (sleep_mode) begin
      // Listed causes outrank a same-cycle other wake
      if (adc_wake || pin_change_wake || comparator_wake) begin
        next_state.rtype = 1'b1;
        next_state.wake  = 1'b1;
      end else if (other_wake) begin
        next_state.rtype = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state        <= '0;
      state.pin_en <= ACF_RST_PIN_EN;
      state.div    <= ACF_RST_DIV;
      state.chsel  <= ACF_RST_CH;
      state.mag    <= ACF_RST_MAG;
    end else begin
      state <= next_state;
    end
  end

  // ******************************************************************
  // Converter and trim outputs
  // ******************************************************************
  // One-cycle start, one cycle after the commit
  assign conv_start        = state.start;
  // Reference stays off whenever power bit is low
  assign ref_power_on      = state.pwr;
  assign channel_onehot    = acf_ch_onehot(state.chsel);
  assign offset_cal_enable = state.cal;
  assign offset_positive   = state.sign;
  assign offset_lsb        = state.cal ? {state.mag, 1'b0} : 4'h0;

  // Wake pulse and reset type
  assign wake_request      = state.wake;
  assign reset_type        = state.rtype;

  // ******************************************************************
  // Pin sharing
  // ******************************************************************
  // Oscillator owns both its pins; misconfigured software cannot steal them
  assign osc_block = osc_in_use;

  always_comb begin
    // Oscillator first, then analog, then I/O
    analog_route = state.pin_en;
    if (osc_block) begin
      analog_route[ACF_CH_OSC_IN]  = 1'b0;
      analog_route[ACF_CH_OSC_OUT] = 1'b0;
    end
    // I/O keeps a pin only when nothing else owns it
    digital_io_enable = ~analog_route;
    if (osc_block) begin
      digital_io_enable[ACF_CH_OSC_IN]  = 1'b0;
      digital_io_enable[ACF_CH_OSC_OUT] = 1'b0;
    end

    // Analog input outranks IR drive on the shared pin
    ir_drive = ir_output_enable && !analog_route[ACF_CH_IR];
    if (ir_drive) begin
      digital_io_enable[ACF_CH_IR] = 1'b0;
    end
  end
endmodule : adc_control_front_end

// ### tb/acf_asserts.sv
// Assertion checker for the converter control front end.
// Assumes one clock aclk and the synchronous active-low aresetn.
`timescale 1ns/100ps
module acf_asserts (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Converter core
  input wire logic       conv_start,
  input wire logic       conv_clk_en,
  input wire logic       conv_done,
  input wire logic       ref_power_on,
  input wire logic [6:0] channel_onehot,
  // Offset trim
  input wire logic       offset_cal_enable,
  input wire logic [3:0] offset_lsb,
  // Pin sharing
  input wire logic       osc_in_use,
  input wire logic       ir_output_enable,
  input wire logic [6:0] analog_route,
  input wire logic [6:0] digital_io_enable,
  input wire logic       ir_drive,
  // Wake-up
  input wire logic       sleep_mode,
  input wire logic       pin_change_wake,
  input wire logic       comparator_wake,
  input wire logic       wake_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_osc_priority: assert property (osc_in_use |-> analog_route[6:5] == 2'h0)
    else $error("oscillator pin routed to converter");
  a_ir_yield: assert property (ir_drive == (ir_output_enable && !analog_route[4]))
    else $error("infrared drive ignores pin priority");
  a_pin_exclusive: assert property ((analog_route & digital_io_enable) == 7'h00)
    else $error("pin both analog and digital");
  a_chan_onehot: assert property ($onehot0(channel_onehot))
    else $error("more than one channel routed");
  a_offset_even: assert property (!offset_lsb[0] && (offset_cal_enable || offset_lsb == 4'h0))
    else $error("offset not twice the code");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_power: assert property (conv_start |-> ref_power_on)
    else $error("start while powered down");
  a_tick_spacing: assert property (conv_clk_en |=> !conv_clk_en [*3])
    else $error("conversion clock faster than one in four");
  a_sel_hold: assert property (conv_start |=> $stable(channel_onehot) [*4])
    else $error("channel changed during conversion");
  a_wake_cause: assert property (wake_request |-> $past(sleep_mode)
    && $past(conv_done || pin_change_wake || comparator_wake))
    else $error("wake without a cause in sleep");
endmodule : acf_asserts
bind adc_control_front_end acf_asserts acf_asserts_i (.*);

// ### tb/acf_core_model.sv
// Behavioural converter core: finishes after a set number of clock ticks.
// Assumes start and clock enable pulses from the front end on aclk.
`timescale 1ns/100ps
module acf_core_model #(
  parameter int TICKS = 4
) (
  // Clock
  input  wire logic        aclk,
  // Front end
  input  wire logic        conv_start,
  input  wire logic        conv_clk_en,
  output logic             conv_done,
  output logic [11:0]      conv_result,
  // Bench
  input  wire logic [11:0] val
);
  int cnt = -1;
  initial conv_done = 1'b0;
  initial conv_result = 12'h5A5;
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    // Stale result toggles so a sample one cycle late never matches
    conv_result <= ~conv_result;
    if (conv_start) begin
      cnt <= 0;
    end else if (conv_clk_en && cnt >= 0) begin
      if (cnt == TICKS - 1) begin
        conv_done <= 1'b1;
        conv_result <= val;
        cnt <= -1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : acf_core_model

// ### tb/adc_control_front_end_tb_top.sv
// Self-checking bench for the converter control front end.
// Assumes the core model as converter; registers over AXI4-Lite.
`timescale 1ns/100ps
module adc_control_front_end_tb_top;
  import acf_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 0, offset_lsb;
  logic [1:0]  bresp, rresp, r;
  logic [11:0] val = 0, conv_result;
  logic [6:0]  channel_onehot, analog_route, digital_io_enable, m;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic osc_in_use = 0, ir_output_enable = 0, sleep_mode = 0, irx;
  logic pin_change_wake = 0, comparator_wake = 0, other_wake = 0;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_clk_en;
  logic conv_done, ref_power_on, offset_cal_enable, offset_positive;
  logic ir_drive, wake_request, reset_type;
  logic done_seen = 0, start_seen = 0, wake_seen = 0;
  int   cyc = 0, last = 0, gap = 0, fail_count = 0, total_checks = 0;
  adc_control_front_end adc_control_front_end_i (.*);
  acf_core_model acf_core_model_i (.*);
  initial forever #2.5 aclk = ~aclk;
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] x);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a; wdata <= x; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (awready) pa = 0;
      if (wready) pw = 0;
      awvalid <= pa;
      wvalid <= pw;
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, ACF_RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] x, output logic [1:0] y);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    x = rdata;
    y = rresp;
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] x;
    logic [1:0]  y;
    rd(a, x, y);
    chk("rresp", y, ACF_RESP_OKAY);
    chk("reg", x, e);
  endtask : rc
  function automatic logic [31:0] cw(logic [1:0] dv, logic rn, logic pw, logic [2:0] s);
    return {25'h0, dv, rn, pw, s};
  endfunction : cw
  function automatic int ratio(logic [1:0] c);
    return c == 2'h0 ? 16 : c == 2'h1 ? 4 : c == 2'h2 ? 64 : 8;
  endfunction : ratio
  task automatic conv(input logic [1:0] dv, input logic [2:0] s);
    logic [31:0] x;
    logic [1:0]  y;
    val <= 12'($urandom);
    done_seen = 0;
    wr(ACF_OFF_CTRL, cw(dv, 1, 1, s));
    wr(ACF_OFF_CTRL, cw(dv, 0, 1, ~s));
    rc(ACF_OFF_CTRL, cw(dv, 1, 1, s));
    while (!done_seen) @(posedge aclk);
    chk("gap", gap, ratio(dv));
    rc(ACF_OFF_RESULT, val);
    wr(ACF_OFF_CTRL, cw(dv, 0, 1, ~s));
    rc(ACF_OFF_CTRL, cw(dv, 0, 1, s));
    rd(ACF_OFF_STAT, x, y);
    chk("done", x[0], 1'b1);
    wr(ACF_OFF_STAT, x & 32'h3);
    rd(ACF_OFF_STAT, x, y);
    chk("clear", x[0], 1'b0);
  endtask : conv
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // ****************
  // Monitor and tests
  // ****************
  always @(posedge aclk) begin
    cyc++;
    if (conv_clk_en) begin
      gap = cyc - last;
      last = cyc;
    end
    if (conv_done) done_seen = 1;
    if (conv_start) start_seen = 1;
    if (wake_request) wake_seen = 1;
    if (cyc > 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hED088A83));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ACF_OFF_PIN_EN, 0);
    rc(ACF_OFF_CTRL, 0);
    rc(ACF_OFF_TRIM, 0);
    rd(5'h14, d, r);
    chk("unmapped", r, ACF_RESP_ERR);
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 32'h7F : $urandom & 32'h7F;
      osc_in_use <= 1'($urandom);
      ir_output_enable <= 1'($urandom) & (i[0] | ~d[4]);
      wr(ACF_OFF_PIN_EN, d);
      rc(ACF_OFF_PIN_EN, d & 32'h7F);
      m = osc_in_use ? 7'h1F : 7'h7F;
      irx = ir_output_enable & ~d[4];
      chk("route", analog_route, d[6:0] & m);
      chk("ir", ir_drive, irx);
      chk("io", digital_io_enable, ~d[6:0] & m & (irx ? 7'h6F : 7'h7F));
    end
    $display("test pins done");
    for (int i = 0; i < 8; i++) begin
      wr(ACF_OFF_CTRL, cw(i[1:0], 0, i[0], i[2:0]));
      rc(ACF_OFF_CTRL, cw(i[1:0], 0, i[0], i[2:0]));
      chk("chan", channel_onehot, i == 7 ? 0 : 1 << i);
      chk("power", ref_power_on, i[0]);
      d = i == 0 ? 32'hFF : $urandom & 32'hFF;
      wr(ACF_OFF_TRIM, d);
      rc(ACF_OFF_TRIM, d & 32'hF8);
      chk("cal", offset_cal_enable, d[7]);
      chk("sign", offset_positive, d[6]);
      chk("lsb", offset_lsb, d[7] ? {d[5:3], 1'b0} : 0);
    end
    $display("test control and trim done");
    start_seen = 0;
    wr(ACF_OFF_CTRL, cw(0, 1, 0, 3));
    rc(ACF_OFF_CTRL, cw(0, 0, 0, 3));
    chk("start", start_seen, 1'b0);
    for (int i = 0; i < 4; i++) conv(i[1:0], 3'(i + 1));
    $display("test conversions done");
    wr(ACF_OFF_STAT, 32'h2);
    sleep_mode <= 1'b1;
    wake_seen = 0;
    conv(2'h1, 3'h0);
    chk("wake", wake_seen, 1'b1);
    rc(ACF_OFF_STAT, 32'h6);
    for (int i = 0; i < 2; i++) begin
      other_wake <= 1'b1;
      @(posedge aclk);
      other_wake <= 1'b0;
      rc(ACF_OFF_STAT, 32'h2);
      chk("rtype", reset_type, 1'b0);
      pin_change_wake <= i == 0;
      comparator_wake <= i == 1;
      @(posedge aclk);
      pin_change_wake <= 1'b0;
      comparator_wake <= 1'b0;
      rc(ACF_OFF_STAT, 32'h6);
      chk("rtype", reset_type, 1'b1);
    end
    $display("test wake done");
    end_of_test();
  end
endmodule : adc_control_front_end_tb_top
